// ---- verilog/pio_params.svh ----
// Constants for the programmed-I/O peripheral port.
// Assumes a 40 MHz system clock; included by the package and the port.
`ifndef PIO_PARAMS_SVH
`define PIO_PARAMS_SVH

// System clock period and receiver settling time, in ns
`define PIO_CLK_NS      25
`define PIO_SETTLE_NS   200
// Least time rounds up to whole cycles
`define PIO_SETTLE_CYC  ((`PIO_SETTLE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)

// Bus word width and device code field inside the code lines
`define PIO_WORD_W      12
`define PIO_CODE_LSB    3
`define PIO_CODE_W      6

// Positions of the pins inside the synchroniser vector
`define PIO_SV_CODE     0
`define PIO_SV_ACC      12
`define PIO_SV_P1       24
`define PIO_SV_P2       25
`define PIO_SV_P4       26
`define PIO_SV_TS1      27
`define PIO_SV_TS3      28
`define PIO_SV_INIT     29
`define PIO_SV_W        30

// Reset values
`define PIO_WORD_RST    12'h000
`define PIO_CNT_RST     4'h0

`endif

// ---- verilog/pio_pkg.sv ----
// Types shared by the programmed-I/O peripheral port.
// Assumes pio_params.svh is on the include path.
`include "pio_params.svh"
`default_nettype none
package pio_pkg;
  typedef logic [`PIO_WORD_W-1:0] pio_word_t;
  typedef logic [`PIO_CODE_W-1:0] pio_code_t;
  typedef logic [`PIO_SV_W-1:0]   pio_sync_t;
  typedef logic [3:0]             pio_cnt_t;
  // Transfer sequencer states, one-hot
  typedef enum logic [3:0] {
    PIO_IDLE   = 4'h1,
    PIO_SETTLE = 4'h2,
    PIO_READY  = 4'h4,
    PIO_DRIVE  = 4'h8
  } pio_state_t;
endpackage
`default_nettype wire

// ---- verilog/pio_periph.sv ----
// Peripheral end of a programmed-I/O expansion bus: device select,
// flag with skip and interrupt, gated pulses, receivers and drivers.
// Assumes bus pins are asynchronous to mclk_in; user side is synchronous.
`include "pio_params.svh"
`default_nettype none
module pio_periph (
  input  wire logic             mclk_in,
  input  wire logic             rst_n_in,
  input  wire logic             initialize_in,
  input  wire pio_pkg::pio_word_t device_code_lines_in,
  input  wire pio_pkg::pio_word_t accumulator_output_lines_in,
  input  wire logic             io_pulse_one_in,
  input  wire logic             io_pulse_two_in,
  input  wire logic             io_pulse_four_in,
  input  wire logic             time_state_first_in,
  input  wire logic             time_state_third_in,
  input  wire logic             neg_levels_in,
  input  wire pio_pkg::pio_code_t dev_code_cfg_in,
  input  wire logic             select_enable_in,
  input  wire logic             dir_input_in,
  input  wire logic             jam_mode_in,
  input  wire pio_pkg::pio_word_t in_data_in,
  input  wire logic             op_done_in,
  output logic                  skip_out,
  output logic                  int_req_out,
  output pio_pkg::pio_word_t    accumulator_input_lines_out,
  output logic                  jam_transfer_request_out,
  output logic                  device_selected_out,
  output pio_pkg::pio_word_t    rx_data_out,
  output logic                  io_pulse_one_out,
  output logic                  io_pulse_two_out,
  output logic                  io_pulse_four_out,
  output pio_pkg::pio_word_t    out_data_out,
  output logic                  out_strobe_out,
  output logic                  op_start_out,
  output logic                  flag_out
);
  import pio_pkg::*;

  localparam pio_cnt_t SETTLE_LAST = pio_cnt_t'(`PIO_SETTLE_CYC - 1);

  // A bit counts as changed only once stages two and three agree
  function automatic pio_sync_t agree(input pio_sync_t a,
                                      input pio_sync_t b,
                                      input pio_sync_t old);
    agree = (a & ~(a ^ b)) | (old & (a ^ b));
  endfunction

  // Pin vector; negative-level bus is inverted before sampling
  pio_sync_t pin_raw;
  assign pin_raw = {initialize_in, time_state_third_in,
                    time_state_first_in, io_pulse_four_in,
                    io_pulse_two_in, io_pulse_one_in,
                    accumulator_output_lines_in, device_code_lines_in}
                   ^ {`PIO_SV_W{neg_levels_in}};

  // Three-stage synchroniser with agreement filter
  pio_sync_t s1_q, s2_q, s3_q, filt_q, prev_q;
  pio_sync_t s1_d, s2_d, s3_d, filt_d, prev_d;
  always_comb begin
    s1_d   = pin_raw;
    s2_d   = s1_q;
    s3_d   = s2_q;
    filt_d = agree(s2_q, s3_q, filt_q);
    prev_d = filt_q;
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      filt_q <= filt_d;
      prev_q <= prev_d;
    end
  end

  // Filtered levels and rising edges of the bus controls
  logic      init_lvl, p1_lvl, p2_edge, p4_lvl, p4_edge;
  logic      ts1_edge, ts3_edge;
  pio_code_t code_fld;
  pio_word_t acc_fld;
  assign init_lvl = filt_q[`PIO_SV_INIT];
  assign p1_lvl   = filt_q[`PIO_SV_P1];
  assign p2_edge  = filt_q[`PIO_SV_P2] & ~prev_q[`PIO_SV_P2];
  assign p4_lvl   = filt_q[`PIO_SV_P4];
  assign p4_edge  = p4_lvl & ~prev_q[`PIO_SV_P4];
  assign ts1_edge = filt_q[`PIO_SV_TS1] & ~prev_q[`PIO_SV_TS1];
  assign ts3_edge = filt_q[`PIO_SV_TS3] & ~prev_q[`PIO_SV_TS3];
  assign code_fld = filt_q[`PIO_SV_CODE + `PIO_CODE_LSB +: `PIO_CODE_W];
  assign acc_fld  = filt_q[`PIO_SV_ACC +: `PIO_WORD_W];

  // Device decode and pulse gating
  logic sel_q, g1_q, g2_q, g4_q;
  logic sel_d, g1_d, g2_d, g4_d;
  always_comb begin
    // Complement-pair wiring reduces to an equality on the code field
    sel_d = (code_fld == dev_code_cfg_in) & select_enable_in
            & ~init_lvl;
    g1_d  = sel_q & p1_lvl;
    g2_d  = sel_q & filt_q[`PIO_SV_P2];
    g4_d  = sel_q & p4_lvl;
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      sel_q <= 1'b0;
      g1_q  <= 1'b0;
      g2_q  <= 1'b0;
      g4_q  <= 1'b0;
    end else begin
      sel_q <= sel_d;
      g1_q  <= g1_d;
      g2_q  <= g2_d;
      g4_q  <= g4_d;
    end
  end

  // Device flag, skip, interrupt and operation start
  logic flag_q, skip_q, int_q, pend_q, start_q;
  logic flag_d, skip_d, int_d, pend_d, start_d;
  always_comb begin
    // Completion wins over a clear in the same cycle
    flag_d  = op_done_in | (flag_q & ~(sel_q & p2_edge));
    skip_d  = (sel_q & p1_lvl & flag_q) ^ neg_levels_in;
    int_d   = flag_q ^ neg_levels_in;
    // Start waits for the first time state to stay in step
    pend_d  = (pend_q & ~ts1_edge) | (sel_q & p2_edge);
    start_d = pend_q & ts1_edge;
    if (init_lvl) begin
      flag_d  = 1'b0;
      skip_d  = neg_levels_in;
      int_d   = neg_levels_in;
      pend_d  = 1'b0;
      start_d = 1'b0;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      flag_q  <= 1'b0;
      skip_q  <= 1'b0;
      int_q   <= 1'b0;
      pend_q  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      flag_q  <= flag_d;
      skip_q  <= skip_d;
      int_q   <= int_d;
      pend_q  <= pend_d;
      start_q <= start_d;
    end
  end

  // Transfer sequencer: settle receivers, then move data on pulse four
  pio_state_t st_q, st_d;
  pio_cnt_t   cnt_q, cnt_d;
  pio_word_t  rx_q, rx_d, out_q, out_d, acc_in_q, acc_in_d;
  logic       strobe_q, strobe_d, jam_q, jam_d;
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    out_d    = out_q;
    strobe_d = 1'b0;
    acc_in_d = {`PIO_WORD_W{neg_levels_in}};
    jam_d    = neg_levels_in;
    // Receivers pass data only with the select as enable
    rx_d     = acc_fld & {`PIO_WORD_W{sel_q}};
    case (st_q)
      PIO_IDLE: begin
        cnt_d = `PIO_CNT_RST;
        if (sel_q) begin
          st_d = PIO_SETTLE;
        end
      end
      PIO_SETTLE: begin
        // Receiver outputs are not trusted until settled
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == SETTLE_LAST) begin
          st_d = PIO_READY;
        end
      end
      PIO_READY: begin
        if (p4_edge && dir_input_in) begin
          st_d = PIO_DRIVE;
        end else if (p4_edge) begin
          out_d    = rx_q;
          strobe_d = 1'b1;
        end
      end
      PIO_DRIVE: begin
        // Drive for the pulse; the third time state ends it at worst
        acc_in_d = in_data_in ^ {`PIO_WORD_W{neg_levels_in}};
        jam_d    = jam_mode_in ^ neg_levels_in;
        if (!p4_lvl || ts3_edge) begin
          st_d     = PIO_READY;
          acc_in_d = {`PIO_WORD_W{neg_levels_in}};
          jam_d    = neg_levels_in;
        end
      end
      default: begin
        st_d = PIO_IDLE;
      end
    endcase
    // Losing select abandons any transfer at once, except an output load on a pulse-four edge in that same cycle
    if (!sel_q) begin
      st_d     = PIO_IDLE;
      acc_in_d = {`PIO_WORD_W{neg_levels_in}};
      jam_d    = neg_levels_in;
    end
    if (init_lvl) begin
      st_d     = PIO_IDLE;
      cnt_d    = `PIO_CNT_RST;
      out_d    = `PIO_WORD_RST;
      strobe_d = 1'b0;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_q     <= PIO_IDLE;
      cnt_q    <= `PIO_CNT_RST;
      rx_q     <= `PIO_WORD_RST;
      out_q    <= `PIO_WORD_RST;
      strobe_q <= 1'b0;
      acc_in_q <= `PIO_WORD_RST;
      jam_q    <= 1'b0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      rx_q     <= rx_d;
      out_q    <= out_d;
      strobe_q <= strobe_d;
      acc_in_q <= acc_in_d;
      jam_q    <= jam_d;
    end
  end

  // Outputs, all straight from flip-flops
  assign skip_out                    = skip_q;
  assign int_req_out                 = int_q;
  assign accumulator_input_lines_out = acc_in_q;
  assign jam_transfer_request_out    = jam_q;
  assign device_selected_out         = sel_q;
  assign rx_data_out                 = rx_q;
  assign io_pulse_one_out            = g1_q;
  assign io_pulse_two_out            = g2_q;
  assign io_pulse_four_out           = g4_q;
  assign out_data_out                = out_q;
  assign out_strobe_out              = strobe_q;
  assign op_start_out                = start_q;
  assign flag_out                    = flag_q;

  // Checks, all on the system clock
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  chk_init_clears_flag: assert property (
    init_lvl |=> !flag_q ##1 !flag_q)
    else $error("flag not cleared by initialise");

  chk_irq_follows_flag: assert property (
    flag_q && !init_lvl |=> int_req_out != neg_levels_in)
    else $error("interrupt request not raised for set flag");

  chk_skip_cause: assert property (
    $past(rst_n_in) && skip_out != neg_levels_in
    |-> $past(sel_q) && $past(flag_q) && $past(p1_lvl))
    else $error("skip without selected flag on pulse one");

  chk_flag_set_wins: assert property (
    op_done_in && !init_lvl |=> flag_q)
    else $error("completion lost against a clear");

  chk_rx_gated_off: assert property (
    !sel_q |=> rx_data_out == `PIO_WORD_RST)
    else $error("receivers pass data while deselected");

  chk_settle_length: assert property (
    $rose(st_q == PIO_SETTLE) ##1 (sel_q && !init_lvl)[*8]
    |-> st_q == PIO_READY)
    else $error("receiver settle time wrong");

  chk_no_early_load: assert property (
    out_strobe_out |-> $past(st_q) == PIO_READY && $past(p4_edge))
    else $error("output word loaded before receivers settled");

  chk_pulse_gating: assert property (
    io_pulse_two_out || io_pulse_four_out |-> $past(sel_q))
    else $error("pulse passed while deselected");

  chk_start_on_ts1: assert property (
    op_start_out |-> $past(pend_q) && $past(ts1_edge))
    else $error("operation start not on first time state");

  chk_jam_in_drive: assert property (
    $past(rst_n_in) && jam_transfer_request_out != neg_levels_in
    |-> $past(st_q) == PIO_DRIVE)
    else $error("jam request outside an input transfer");

  cov_output_load: cover property (out_strobe_out);
  cov_input_jam: cover property (
    st_q == PIO_DRIVE && jam_mode_in);
  cov_skip_flag: cover property (
    flag_q && sel_q && p1_lvl ##1 skip_out != neg_levels_in);
  cov_start_op: cover property (op_start_out);

endmodule
`default_nettype wire

// ---- dv/pio_proc_model.sv ----
// Processor side of the programmed-I/O bus: code, data, pulses, states.
// Assumes the peripheral's clock; every line flips when neg_in is high.
`default_nettype none
module pio_proc_model (
  input  wire logic               clk_in,
  input  wire logic               neg_in,
  input  wire logic               skip_in,
  input  wire logic               int_req_in,
  input  wire pio_pkg::pio_word_t acc_in,
  input  wire logic               jam_in,
  output logic                    init_out,
  output pio_pkg::pio_word_t      code_out,
  output pio_pkg::pio_word_t      acc_out,
  output logic [2:0]              pulse_out,
  output logic [1:0]              ts_out,
  output logic                    run_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  logic       init_q = 1'b0;
  pio_word_t  code_q = 12'h000;
  pio_word_t  acc_q  = 12'h000;
  pio_word_t  ac_reg = 12'h000;
  pio_word_t  pc_q   = 12'h000;
  logic [2:0] pul_q  = 3'h0;
  logic [1:0] ts_q   = 2'h0;
  logic       int_en = 1'b1;

  // Negative-level bus only inverts every line
  assign init_out  = init_q ^ neg_in;
  assign code_out  = code_q ^ {12{neg_in}};
  assign acc_out   = acc_q ^ {12{neg_in}};
  assign pulse_out = pul_q ^ {3{neg_in}};
  assign ts_out    = ts_q ^ {2{neg_in}};
  // The model is always executing, so run stays active
  assign run_out   = 1'b1 ^ neg_in;

  // Interrupt jumps to zero and masks all further ones; nothing re-enables them
  always @(posedge clk_in) begin
    if ((int_req_in ^ neg_in) && int_en) begin
      int_en <= 1'b0;
      pc_q   <= 12'h000;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // Pulse held ten cycles so the three-flop sync surely sees it;
  // the answer is sampled just before it falls
  task automatic pulse(input int k, output logic s, output pio_word_t w,
                       output logic j);
    pul_q[k] <= 1'b1;
    tick(9);
    #1;
    s = skip_in ^ neg_in;
    w = acc_in ^ {12{neg_in}};
    j = jam_in ^ neg_in;
    tick(1);
    pul_q[k] <= 1'b0;
    tick(4);
  endtask

  // One whole transfer: code, pulses one, two and four, time states
  task automatic iot(input pio_code_t c, input pio_word_t d,
                     output logic s, output pio_word_t w, output logic j);
    logic      x;
    pio_word_t y;
    code_q <= {3'h0, c, 3'h0};
    acc_q  <= d;
    tick(16);
    pulse(0, s, y, x);
    pulse(1, x, y, x);
    ts_q[0] <= 1'b1;
    tick(3);
    ts_q[0] <= 1'b0;
    tick(3);
    pulse(2, x, w, j);
    ac_reg = j ? w : (ac_reg | w);
    ts_q[1] <= 1'b1;
    tick(3);
    ts_q[1] <= 1'b0;
    code_q <= 12'h000;
    // Long enough for the synchronised select to drop before return
    tick(8);
  endtask

  task automatic init_pulse();
    init_q <= 1'b1;
    tick(6);
    init_q <= 1'b0;
    tick(6);
  endtask
endmodule
`default_nettype wire

// ---- dv/tb_positive_io_bus_peripheral_port.sv ----
// Self-checking bench for the programmed-I/O peripheral port.
// Assumes pio_proc_model plays the processor on the bus side.
`default_nettype none
module tb_positive_io_bus_peripheral_port;
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  logic      mclk = 1'b0, rst_n = 1'b0, neg = 1'b0, sel_en = 1'b1;
  logic      dir = 1'b0, jam = 1'b0, done = 1'b0, s, j;
  pio_code_t cfg = 6'h2a;
  pio_word_t din = 12'h000, w;
  int        err_total = 0, n_tests = 0;
  int        n_start = 0, n_stb = 0, n_sel = 0, n_gp = 0;
  wire       init_w, skip, irq, jreq, sel, stb, start, flag;
  wire [2:0] pul_w, gp;
  wire [1:0] ts_w;
  wire pio_word_t code_w, acc_w, accin, rx, od;

  always #12.5 mclk = ~mclk;

  pio_proc_model pio_proc_model_i (
    .clk_in(mclk), .neg_in(neg), .skip_in(skip), .int_req_in(irq),
    .acc_in(accin), .jam_in(jreq), .init_out(init_w), .code_out(code_w),
    .acc_out(acc_w), .pulse_out(pul_w), .ts_out(ts_w), .run_out());

  pio_periph pio_periph_i (
    .mclk_in(mclk), .rst_n_in(rst_n), .initialize_in(init_w),
    .device_code_lines_in(code_w), .accumulator_output_lines_in(acc_w),
    .io_pulse_one_in(pul_w[0]), .io_pulse_two_in(pul_w[1]),
    .io_pulse_four_in(pul_w[2]), .time_state_first_in(ts_w[0]),
    .time_state_third_in(ts_w[1]), .neg_levels_in(neg),
    .dev_code_cfg_in(cfg), .select_enable_in(sel_en), .dir_input_in(dir),
    .jam_mode_in(jam), .in_data_in(din), .op_done_in(done),
    .skip_out(skip), .int_req_out(irq), .accumulator_input_lines_out(accin),
    .jam_transfer_request_out(jreq), .device_selected_out(sel),
    .rx_data_out(rx), .io_pulse_one_out(gp[0]), .io_pulse_two_out(gp[1]),
    .io_pulse_four_out(gp[2]), .out_data_out(od), .out_strobe_out(stb),
    .op_start_out(start), .flag_out(flag));

  // Count starts, loads, and cycles with select or a gated pulse; scenarios judge the totals afterwards
  always @(posedge mclk) begin
    if (start === 1'b1) n_start++;
    if (stb === 1'b1) n_stb++;
    if (sel === 1'b1) n_sel++;
    if (gp !== 3'h0) n_gp++;
  end

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Completion pulse, then time for the flag and request to follow
  task automatic raise_flag();
    done <= 1'b1;
    @(posedge mclk);
    done <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(flag === 1'b1 && irq === !neg, "flag set");
  endtask

  // Output transfer: skip on a set flag, clear, start, load
  task automatic t_output();
    raise_flag();
    n_start = 0;
    n_stb = 0;
    n_sel = 0;
    pio_proc_model_i.iot(6'h2a, 12'ha5c, s, w, j);
    chk(s === 1'b1, "skip");
    chk(flag === 1'b0 && irq === 1'b0, "flag clear");
    chk(n_start == 1, "start");
    chk(od === 12'ha5c && n_stb == 1, "load");
    chk(n_sel > 12 && rx === 12'h000, "select");
  endtask

  // Input transfers, plain and jam; the drive must end afterwards
  task automatic t_input();
    dir <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      jam <= i[0];
      din <= 12'h3c1 ^ {12{i[0]}};
      @(posedge mclk);
      pio_proc_model_i.iot(6'h2a, 12'h000, s, w, j);
      chk(s === 1'b0, "no skip");
      chk(w === (12'h3c1 ^ {12{i[0]}}), "input word");
      chk(j === i[0], "jam");
      chk(accin === 12'h000 && jreq === 1'b0, "idle");
    end
    dir <= 1'b0;
  endtask

  // Foreign code, then own code with select disabled: no response
  task automatic t_deaf();
    raise_flag();
    for (int i = 0; i < 2; i++) begin
      sel_en <= ~i[0];
      @(posedge mclk);
      n_sel = 0;
      n_gp = 0;
      n_stb = 0;
      pio_proc_model_i.iot(i[0] ? 6'h2a : 6'h15, 12'h0f0, s, w, j);
      chk(s === 1'b0 && flag === 1'b1, "deaf skip");
      chk(n_sel == 0, "deaf select");
      chk(n_gp == 0, "deaf pulses");
      chk(od === 12'ha5c && n_stb == 0, "deaf load");
    end
    sel_en <= 1'b1;
  endtask

  // Negative-level bus after a fresh reset, input transfer
  task automatic t_neg();
    rst_n <= 1'b0;
    neg <= 1'b1;
    dir <= 1'b1;
    jam <= 1'b0;
    din <= 12'h5a3;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    raise_flag();
    pio_proc_model_i.iot(6'h2a, 12'h000, s, w, j);
    chk(s === 1'b1 && w === 12'h5a3 && j === 1'b0, "neg bus");
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(flag === 1'b0 && sel === 1'b0 && accin === 12'h000, "reset");
    t_output();
    t_input();
    t_deaf();
    pio_proc_model_i.init_pulse();
    chk(flag === 1'b0 && irq === 1'b0 && od === 12'h000, "init");
    t_neg();
    give_verdict();
  end

  // The run needs about five hundred cycles; a hang is cut well beyond
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
